// ---- rtl/csd_defines.svh ----
// constants for the chip select decode unit: offsets, fields, reset values
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

`define CSD_NBANK 8
`define CSD_BANK0_OFF 12'h080
`define CSD_BANK_STRIDE 12'h00C
`define CSD_BASE_REL 12'h000
`define CSD_MASK_REL 12'h004
`define CSD_CTRL_REL 12'h008
`define CSD_IRQ_STS_OFF 12'h0E0
`define CSD_IRQ_EN_OFF 12'h0E4
`define CSD_IRQ_CLR_OFF 12'h0E8

`define CSD_BASE_LSB 16
`define CSD_MASK_LSB 16
`define CSD_WP_BIT 8
`define CSD_VLD_BIT 0
`define CSD_SRW_MSB 15
`define CSD_SRW_LSB 14
`define CSD_INIT_WAITS_MSB 13
`define CSD_INIT_WAITS_LSB 10
`define CSD_AUTO_ACK_BIT 8
`define CSD_CTRL_RW_MASK 16'hFDFF

`define CSD_BASE_RST 16'h0000
`define CSD_MASK_RST 16'h0000
`define CSD_CTRL0_RST 16'h3D00
`define CSD_CTRL_RST 16'h0000

`define CSD_EV_WP 0
`define CSD_EV_EXT 1
`define CSD_NEV 2

`endif

// ---- rtl/csd_pkg.sv ----
// types shared by the chip select decode unit
package csd_pkg;
   typedef enum logic [0:0] {ST_IDLE, ST_WAIT} csd_state_t;
   typedef logic [15:0] csd_half_t;
endpackage

// ---- rtl/csd_bank_match.sv ----
// one bank's address compare under its don't-care mask
`timescale 1ns/100ps
`include "csd_defines.svh"
module csd_bank_match (
   // bank settings
   input wire csd_pkg::csd_half_t i_base,
   input wire csd_pkg::csd_half_t i_mask,
   // upper half of the access address
   input wire csd_pkg::csd_half_t i_addr_hi,
   // result
   output logic o_match
);
   // set mask bits drop out of the compare
   assign o_match = ((i_addr_hi ^ i_base) & ~i_mask) == 16'h0000;
endmodule

// ---- rtl/csd_top.sv ----
// eight-bank chip select decode and wait-state control with apb registers
// Operation
// - each bank compares its 16-bit base against address bits 31 to 16 to detect a hit.
// - each set mask bit makes its address bit a don't-care, widening the block.
// - a write hitting a write-protected bank gets no select and raises an access error.
// - a bank's select never asserts until its valid bit is set, except the boot select.
// - reset clears every bank's valid bit.
// - bank 0 control resets to values of its own so boot memory decodes at once.
// - secondary read waits code 00 off and 01..11 as 0..2 waits for later reads with ack on.
// - initial waits give 0 to 15 wait states before the internal acknowledge.
// - an external acknowledge takes precedence and ends the bus cycle.
// - with auto-acknowledge on the internal acknowledge follows the wait count, else none.
// - after reset the boot select fires on every access until bank 0 is made valid.
`timescale 1ns/100ps
`include "csd_defines.svh"
module csd_top (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // internal bus access
   input wire logic i_acc_valid,
   input wire logic i_acc_write,
   input wire logic i_acc_secondary,
   input wire logic [31:0] i_acc_addr,
   output logic o_acc_ack,
   output logic o_acc_err,
   // external pins
   input wire logic i_transfer_acknowledge_n,
   output logic [7:0] o_cs_n,
   // interrupt
   output logic o_irq
);
   localparam int NB = `CSD_NBANK;

   csd_pkg::csd_half_t base_ff [NB];
   csd_pkg::csd_half_t mask_ff [NB];
   csd_pkg::csd_half_t ctrl_ff [NB];
   logic [NB-1:0] wp_ff;
   logic [NB-1:0] vld_ff;
   logic [NB-1:0] match;
   logic [NB-1:0] hitv;
   logic [NB-1:0] mism;
   logic [NB-1:0] bank_wsel;
   logic [NB-1:0] bank_msel;
   logic [NB-1:0] bank_csel;
   logic [NB-1:0] bank_bsel;
   logic [NB-1:0] nxt_cs_n;
   logic [`CSD_NEV-1:0] sts_ff;
   logic [`CSD_NEV-1:0] en_ff;
   logic [`CSD_NEV-1:0] ev;
   logic [31:0] addr_ff;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic auto_ack_ff;
   logic xack_s1_ff;
   logic xack_s2_ff;
   logic int_done_ff;
   logic [4:0] wcyc_ff;
   logic [3:0] tgt_ff;
   logic [2:0] sel;
   logic any_hit;
   logic take;
   logic blocked;
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic [31:0] nxt_rdata;
   logic [1:0] srw;
   csd_pkg::csd_state_t st_ff;

   // external acknowledge pin synchroniser
   // the pin is seen two cycles late, so its release reaches the sequencer after the ack cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         xack_s1_ff <= 1'b1;
         xack_s2_ff <= 1'b1;
      end else begin
         xack_s1_ff <= i_transfer_acknowledge_n;
         xack_s2_ff <= xack_s1_ff;
      end
   end

   // apb decode
   assign wr_en = i_psel & i_penable & i_pwrite & o_pready;
   assign rd_setup = i_psel & ~i_penable;

   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_bank
         localparam logic [11:0] BOFF = 12'(`CSD_BANK0_OFF + g * `CSD_BANK_STRIDE);
         assign bank_bsel[g] = i_paddr == BOFF + `CSD_BASE_REL;
         assign bank_msel[g] = i_paddr == BOFF + `CSD_MASK_REL;
         assign bank_csel[g] = i_paddr == BOFF + `CSD_CTRL_REL;
         assign bank_wsel[g] = bank_bsel[g] | bank_msel[g] | bank_csel[g];

         csd_bank_match csd_bank_match_i (
            .i_base(base_ff[g]),
            .i_mask(mask_ff[g]),
            .i_addr_hi(i_acc_addr[31:16]),
            .o_match(match[g])
         );

         // bank 0 hits every access as boot select until made valid; others also need bank 0 valid
         if (g == 0) begin : g_boot
            assign hitv[g] = ~vld_ff[0] | (match[g] & vld_ff[g]);
         end else begin : g_norm
            assign hitv[g] = match[g] & vld_ff[g] & vld_ff[0];
         end

         // helper for decode check on the held address
         assign mism[g] = ((addr_ff[31:16] ^ base_ff[g]) & ~mask_ff[g]) != 16'h0000;

         always_ff @(posedge i_clk_sys) begin
            if (!i_nrst) begin
               base_ff[g] <= `CSD_BASE_RST;
               mask_ff[g] <= `CSD_MASK_RST;
               wp_ff[g] <= 1'b0;
               vld_ff[g] <= 1'b0;
               ctrl_ff[g] <= (g == 0) ? `CSD_CTRL0_RST : `CSD_CTRL_RST;
            end else if (wr_en) begin
               if (bank_bsel[g]) begin
                  base_ff[g] <= i_pwdata[`CSD_BASE_LSB +: 16];
               end else if (bank_msel[g]) begin
                  mask_ff[g] <= i_pwdata[`CSD_MASK_LSB +: 16];
                  wp_ff[g] <= i_pwdata[`CSD_WP_BIT];
                  vld_ff[g] <= i_pwdata[`CSD_VLD_BIT];
               end else if (bank_csel[g]) begin
                  ctrl_ff[g] <= i_pwdata[15:0] & `CSD_CTRL_RW_MASK;
               end
            end
         end
      end
   endgenerate

   assign mapped = (|bank_wsel) | (i_paddr == `CSD_IRQ_STS_OFF) |
      (i_paddr == `CSD_IRQ_EN_OFF) | (i_paddr == `CSD_IRQ_CLR_OFF);

   // read data mux, reserved bits zero, clear register reads zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      for (int k = 0; k < NB; k++) begin
         if (bank_bsel[k]) begin
            nxt_rdata = {base_ff[k], 16'h0000};
         end else if (bank_msel[k]) begin
            nxt_rdata = {mask_ff[k], 7'h00, wp_ff[k], 7'h00, vld_ff[k]};
         end else if (bank_csel[k]) begin
            nxt_rdata = {16'h0000, ctrl_ff[k]};
         end
      end
      if (i_paddr == `CSD_IRQ_STS_OFF) begin
         nxt_rdata = {30'h0000_0000, sts_ff};
      end else if (i_paddr == `CSD_IRQ_EN_OFF) begin
         nxt_rdata = {30'h0000_0000, en_ff};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         o_prdata <= 32'h0000_0000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= 1'b1;
         if (rd_setup) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : nxt_rdata;
            o_pslverr <= ~mapped;
         end
      end
   end

   // lowest hitting bank wins
   always_comb begin
      sel = 3'h0;
      any_hit = 1'b0;
      for (int k = NB - 1; k >= 0; k--) begin
         if (hitv[k]) begin
            sel = 3'(k);
            any_hit = 1'b1;
         end
      end
   end

   assign take = (st_ff == csd_pkg::ST_IDLE) & i_acc_valid & ~o_acc_ack & ~o_acc_err;
   assign blocked = i_acc_write & wp_ff[sel];
   assign srw = ctrl_ff[sel][`CSD_SRW_MSB:`CSD_SRW_LSB];

   // wait count for the access being taken
   always_comb begin
      nxt_cnt = ctrl_ff[sel][`CSD_INIT_WAITS_MSB:`CSD_INIT_WAITS_LSB];
      if (i_acc_secondary && !i_acc_write && srw != 2'b00 &&
            ctrl_ff[sel][`CSD_AUTO_ACK_BIT]) begin
         nxt_cnt = 4'(srw - 2'b01);
      end
   end

   always_comb begin
      nxt_cs_n = 8'hFF;
      nxt_cs_n[sel] = 1'b0;
   end

   // access sequencer
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         st_ff <= csd_pkg::ST_IDLE;
         o_cs_n <= 8'hFF;
         o_acc_ack <= 1'b0;
         o_acc_err <= 1'b0;
         cnt_ff <= 4'h0;
         auto_ack_ff <= 1'b0;
         addr_ff <= 32'h0000_0000;
         int_done_ff <= 1'b0;
      end else begin
         o_acc_ack <= 1'b0;
         o_acc_err <= 1'b0;
         case (st_ff)
            csd_pkg::ST_IDLE: begin
               if (take) begin
                  addr_ff <= i_acc_addr;
                  if (!any_hit) begin
                     o_acc_ack <= 1'b1;
                     int_done_ff <= 1'b0;
                  end else if (blocked) begin
                     o_acc_err <= 1'b1;
                  end else begin
                     o_cs_n <= nxt_cs_n;
                     cnt_ff <= nxt_cnt;
                     auto_ack_ff <= ctrl_ff[sel][`CSD_AUTO_ACK_BIT];
                     st_ff <= csd_pkg::ST_WAIT;
                  end
               end
            end
            csd_pkg::ST_WAIT: begin
               if (!xack_s2_ff) begin
                  o_acc_ack <= 1'b1;
                  int_done_ff <= 1'b0;
                  o_cs_n <= 8'hFF;
                  st_ff <= csd_pkg::ST_IDLE;
               end else if (auto_ack_ff && cnt_ff == 4'h0) begin
                  o_acc_ack <= 1'b1;
                  int_done_ff <= 1'b1;
                  o_cs_n <= 8'hFF;
                  st_ff <= csd_pkg::ST_IDLE;
               end else if (auto_ack_ff) begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            default: st_ff <= csd_pkg::ST_IDLE;
         endcase
      end
   end

   // events: write-protect error, externally terminated cycle
   assign ev[`CSD_EV_WP] = take & any_hit & blocked;
   assign ev[`CSD_EV_EXT] = (st_ff == csd_pkg::ST_WAIT) & ~xack_s2_ff;

   // sticky status, set beats clear
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         sts_ff <= '0;
         en_ff <= '0;
         o_irq <= 1'b0;
      end else begin
         if (wr_en && i_paddr == `CSD_IRQ_EN_OFF) begin
            en_ff <= i_pwdata[`CSD_NEV-1:0];
         end
         if (wr_en && i_paddr == `CSD_IRQ_CLR_OFF) begin
            sts_ff <= (sts_ff & ~i_pwdata[`CSD_NEV-1:0]) | ev;
         end else begin
            sts_ff <= sts_ff | ev;
         end
         o_irq <= |(sts_ff & en_ff);
      end
   end

   // helper: cycles from entering the wait state, and the count loaded
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         wcyc_ff <= 5'h00;
         tgt_ff <= 4'h0;
      end else if (take) begin
         wcyc_ff <= 5'h00;
         tgt_ff <= nxt_cnt;
      end else if (st_ff == csd_pkg::ST_WAIT) begin
         wcyc_ff <= wcyc_ff + 5'h01;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   a_wp_blocks_select: assert property (ev[`CSD_EV_WP] |=> o_acc_err && o_cs_n == 8'hFF)
      else $error("protected write was selected or not flagged");
   a_invalid_bank_quiet: assert property (
      (~o_cs_n[7:1] & ~(vld_ff[7:1] & {7{vld_ff[0]}})) == 7'h00)
      else $error("select asserted on an invalid bank");
   a_boot_all_access: assert property (take && !vld_ff[0] && !blocked |=> !o_cs_n[0])
      else $error("boot select missing after reset");
   a_decode_hit: assert property (((~o_cs_n & mism & {{7{1'b1}}, vld_ff[0]}) == 8'h00))
      else $error("select asserted for a non-matching address");
   a_one_select: assert property ($onehot0(~o_cs_n))
      else $error("more than one select asserted");
   a_select_held: assert property (st_ff == csd_pkg::ST_WAIT |-> o_cs_n != 8'hFF)
      else $error("select dropped while the access waits");
   a_ack_ends_select: assert property (o_acc_ack || o_acc_err |-> o_cs_n == 8'hFF)
      else $error("select still asserted after the access ended");
   a_ext_ack_wins: assert property (
      st_ff == csd_pkg::ST_WAIT && !xack_s2_ff |=> o_acc_ack && o_cs_n == 8'hFF)
      else $error("external acknowledge did not end the cycle");
   a_no_auto_ack: assert property (
      st_ff == csd_pkg::ST_WAIT && !auto_ack_ff && xack_s2_ff |=> !o_acc_ack)
      else $error("internal acknowledge without auto-acknowledge");
   a_count_down: assert property (
      st_ff == csd_pkg::ST_WAIT && auto_ack_ff && xack_s2_ff && cnt_ff != 4'h0
      |=> cnt_ff == $past(cnt_ff) - 4'h1)
      else $error("wait count did not step down");
   a_wait_length: assert property (
      o_acc_ack && int_done_ff |-> wcyc_ff == {1'b0, tgt_ff} + 5'h01)
      else $error("wait state count wrong");

   // checked on the first edge out of reset, while reset is no longer disabling it
   property p_reset_values;
      @(posedge i_clk_sys) $rose(i_nrst) |-> vld_ff == 8'h00 && ctrl_ff[0] == `CSD_CTRL0_RST;
   endproperty
   a_reset_state: assert property (p_reset_values)
      else $error("bank reset values wrong");

   c_protect_err: cover property (ev[`CSD_EV_WP]);
   c_ext_ack: cover property (ev[`CSD_EV_EXT]);
   c_secondary: cover property (take && i_acc_secondary && srw != 2'b00 && any_hit);
   c_boot: cover property (take && !vld_ff[0]);
   c_no_hit: cover property (take && !any_hit);
endmodule

// ---- verification/csd_ext_mem.sv ----
// model of the external memory side that drives the transfer acknowledge pin
`timescale 1ns/100ps
module csd_ext_mem (
   // clock
   input wire logic i_clk_sys,
   // selects from the unit
   input wire logic [7:0] i_cs_n,
   // behaviour set by the bench
   input wire logic i_ack_en,
   input wire logic [3:0] i_delay,
   // acknowledge pin, pulled up when released
   output logic o_transfer_acknowledge_n
);
   logic [3:0] cnt_ff;
   always_ff @(posedge i_clk_sys) begin
      if (&i_cs_n) begin
         cnt_ff <= 4'h0;
      end else if (cnt_ff != 4'hF) begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
   // acknowledge only while selected and after the programmed delay
   assign o_transfer_acknowledge_n = !(i_ack_en && !(&i_cs_n) && (cnt_ff >= i_delay));
endmodule

// ---- verification/chip_select_decode_control_tb.sv ----
// self-checking bench for the chip select decode unit
`timescale 1ns/100ps
`include "csd_defines.svh"
module chip_select_decode_control_tb;
   logic clk, nrst, psel, penable, pwrite, a_valid, a_write, a_sec, xack_n, pready, pslverr;
   logic ack, err, irq, m_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, a_addr, rd;
   logic [7:0] cs_n;
   logic [3:0] m_dly;
   int error_cnt = 0;
   int compares = 0;
   int lat;
   logic e;
   logic [7:0] cs;
   csd_top csd_top_i (.i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_acc_valid(a_valid), .i_acc_write(a_write),
      .i_acc_secondary(a_sec), .i_acc_addr(a_addr), .o_acc_ack(ack), .o_acc_err(err),
      .i_transfer_acknowledge_n(xack_n), .o_cs_n(cs_n), .o_irq(irq));
   csd_ext_mem csd_ext_mem_i (.i_clk_sys(clk), .i_cs_n(cs_n), .i_ack_en(m_en),
      .i_delay(m_dly), .o_transfer_acknowledge_n(xack_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [11:0] ra(input int bank, input logic [11:0] rel);
      return `CSD_BANK0_OFF + 12'(bank) * `CSD_BANK_STRIDE + rel;
   endfunction
   // one access: latency from take edge, and every select seen asserted during it
   task automatic acc(input logic [31:0] ad, input logic w, input logic s);
      @(posedge clk);
      a_valid <= 1'b1;
      a_addr <= ad;
      a_write <= w;
      a_sec <= s;
      lat = 0;
      cs = 8'hFF;
      e = 1'b0;
      do begin
         @(posedge clk);
         #1;
         lat++;
         cs = cs & cs_n;
         e = e | err;
      end while (ack !== 1'b1 && err !== 1'b1 && lat < 40);
      if (ack !== 1'b1 && err !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t access not ended", $time);
      end
      @(posedge clk);
      a_valid <= 1'b0;
   endtask
   task automatic conclude();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #300us;
      error_cnt++;
      conclude();
   end
   initial begin
      {nrst, psel, penable, pwrite, a_valid, a_write, a_sec, m_en} = '0;
      paddr = '0;
      pwdata = '0;
      a_addr = '0;
      m_dly = 4'h2;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      apb(0, ra(0, `CSD_CTRL_REL), 0); chk(rd, 32'h0000_3D00);
      apb(0, ra(1, `CSD_CTRL_REL), 0); chk(rd, 32'h0000_0000);
      for (int b = 0; b < 8; b++) begin
         apb(0, ra(b, `CSD_MASK_REL), 0); chk(rd, 32'h0);
      end
      apb(0, 12'h0FC, 0); chk({rd[30:0], e}, 32'h1);
      acc(32'h1234_0000, 0, 0); chk({cs, 24'(lat)}, {8'hFE, 24'd17});
      apb(1, ra(1, `CSD_BASE_REL), 32'h0010_0000);
      apb(1, ra(1, `CSD_MASK_REL), 32'h0001_0001);
      apb(1, ra(1, `CSD_CTRL_REL), 32'h0000_0D00);
      acc(32'h0011_0000, 0, 0); chk({cs, 24'(lat)}, {8'hFE, 24'd17});
      apb(1, ra(0, `CSD_MASK_REL), 32'h0000_0001);
      apb(1, ra(0, `CSD_CTRL_REL), 32'h0000_0100);
      acc(32'h0000_0010, 1, 0); chk({cs, 24'(lat)}, {8'hFE, 24'd2});
      acc(32'h0011_0000, 0, 0); chk({cs, 24'(lat)}, {8'hFD, 24'd5});
      acc(32'h0012_0000, 0, 0); chk({cs, 24'(lat)}, {8'hFF, 24'd1});
      apb(1, ra(2, `CSD_BASE_REL), 32'h0020_0000);
      acc(32'h0020_0000, 0, 0); chk({cs, 24'(lat)}, {8'hFF, 24'd1});
      for (int s = 0; s < 4; s++) begin
         apb(1, ra(1, `CSD_CTRL_REL), {16'h0, 2'(s), 14'h0D00});
         acc(32'h0010_0004, 0, 1); chk(lat, (s == 0) ? 5 : s + 1);
         acc(32'h0010_0004, 1, 1); chk(lat, 5);
      end
      apb(1, `CSD_IRQ_EN_OFF, 32'h3);
      apb(1, ra(1, `CSD_MASK_REL), 32'h0001_0101);
      acc(32'h0011_0000, 1, 0); chk({cs, 7'h0, e}, {8'hFF, 8'h01});
      acc(32'h0011_0000, 0, 0); chk(cs, 8'hFD);
      apb(0, `CSD_IRQ_STS_OFF, 0); chk({rd[0], irq}, 2'b11);
      apb(1, `CSD_IRQ_CLR_OFF, 32'h1);
      apb(0, `CSD_IRQ_STS_OFF, 0); chk({rd[0], irq}, 2'b00);
      m_en <= 1'b1;
      apb(1, ra(1, `CSD_CTRL_REL), 32'h0000_0000);
      acc(32'h0011_0000, 0, 0); chk({cs, 7'h0, ack}, {8'hFD, 8'h01});
      apb(0, `CSD_IRQ_STS_OFF, 0); chk({rd[1], irq}, 2'b11);
      apb(1, ra(1, `CSD_CTRL_REL), 32'h0000_3D00);
      acc(32'h0011_0000, 0, 0); chk(lat < 17, 1);
      conclude();
   end
endmodule
